// ===== dsgc_gate_ctrl.sv
// Purpose: Deep-sleep clock gating control with run and sleep companions
// Assumes: APB slave, zero wait states, one clock MCLK, reset SRST
// Notes:   Gate bits: watchdog, hibernate, converter 0, pwm
//          Reserved gate bits read zero and drop writes
//          Unit enables follow the selected register one edge later
//
// Summary of operation
// RULE1: Gate bit one clocks and enables its unit; zero stops and disables it.
// RULE2: Access to an unclocked unit is answered with a bus fault.
// RULE3: Deep-sleep gate register resets to 0x00000040.
// RULE4: Bit 6 gates hibernate clock, read-write, resets to one.
// RULE5: Bit 20 gates pwm clock, read-write, resets to zero.
// RULE6: Bit 16 gates converter 0 clock, read-write, resets to zero.
// RULE7: Bit 3 gates watchdog clock, read-write, resets to zero.
// RULE8: All other bits read zero and ignore writes.
// RULE9: Software writes back reserved bits unchanged on read-modify-write.
// RULE10: Separate run, sleep, deep-sleep gate registers; deep one acts in deep sleep.
// RULE11: Sleep and deep-sleep gates apply only with automatic gating set.
// RULE12: Software enables needed units before touching them.
// RULE13: Deep-sleep gate decoded as word at 0x120 from base 0x400fe000.
// RULE14: Without automatic gating or deep sleep, deep gate has no effect.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dsgc_consts.svh"

module dsgc_gate_ctrl
	import dsgc_pkg::*;
#(
	parameter int NUM_UNITS = `DSGC_NUM_UNITS
) (
	// Clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 SRST,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [31:0]          PADDR,
	input  wire logic [31:0]          PWDATA,
	input  wire logic [3:0]           PSTRB,
	output logic                      PREADY,
	output logic [31:0]               PRDATA,
	output logic                      PSLVERR,
	// Power mode requests
	input  wire logic                 SLEEP_REQ,
	input  wire logic                 DEEP_SLEEP_REQ,
	// Unit accesses and faults
	input  wire logic [NUM_UNITS-1:0] UNIT_ACC,
	output logic [NUM_UNITS-1:0]      UNIT_FAULT,
	// Unit clocks
	output logic [NUM_UNITS-1:0]      UNIT_CLK_EN,
	output logic [NUM_UNITS-1:0]      UNIT_CLK,
	// Interrupt
	output logic                      IRQ
);

	// Byte-lane merge limited to writable bits
	function automatic logic [31:0] dsgc_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb,
		input logic [31:0] mask
	);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old_v & ~m) | (new_v & m);
	endfunction

	// Register state
	logic [31:0]      run_clock_gate_0_r;
	logic [31:0]      sleep_clock_gate_0_r;
	logic [31:0]      deep_sleep_clock_gate_0_r;
	logic [31:0]      run_clock_configuration_r;
	logic [31:0]      irq_stat_r;
	logic [31:0]      irq_en_r;
	dsgc_mode_type    mode_r;
	dsgc_mode_type    mode_nxt;
	dsgc_apb_rsp_type rsp_r;
	dsgc_apb_rsp_type rsp_nxt;
	dsgc_apb_req_type req;

	// Decode and selection
	logic                 setup;
	logic                 access;
	logic                 base_hit;
	logic [11:0]          ofs;
	logic                 wr_en;
	logic                 auto_gating_select;
	logic [31:0]          gate_sel;
	logic [NUM_UNITS-1:0] unit_on;
	logic [NUM_UNITS-1:0] fault_evt;
	logic [31:0]          clr_val;
	logic                 wr_run;
	logic                 wr_slp;
	logic                 wr_deep;
	logic                 wr_cfg;
	logic                 wr_ien;
	logic                 wr_clr;

	// System control page of the register block
	localparam logic [19:0] BASE_PAGE = 20'(`DSGC_SYSCTL_BASE >> 12);

	assign req.addr  = PADDR;
	assign req.write = PWRITE;
	assign req.wdata = PWDATA;
	assign req.strb  = PSTRB;

	assign setup    = PSEL & ~PENABLE;
	assign access   = PSEL & PENABLE;
	assign base_hit = (req.addr[31:12] == BASE_PAGE); // see RULE13
	assign ofs      = req.addr[11:0];
	assign wr_en    = access & req.write & ~rsp_r.err;

	// Write strobe per register
	assign wr_run  = wr_en && ofs == `DSGC_OFS_RUN_GATE;
	assign wr_slp  = wr_en && ofs == `DSGC_OFS_SLP_GATE;
	assign wr_deep = wr_en && ofs == `DSGC_OFS_DEEP_GATE; // see RULE13
	assign wr_cfg  = wr_en && ofs == `DSGC_OFS_RUN_CFG;
	assign wr_ien  = wr_en && ofs == `DSGC_OFS_IRQ_EN;
	assign wr_clr  = wr_en && ofs == `DSGC_OFS_IRQ_CLR;

	// Setup-phase decode and read data
	always_comb begin
		rsp_nxt.err   = 1'b0;
		rsp_nxt.rdata = 32'h00000000;
		if (!base_hit || req.addr[1:0] != 2'h0) begin
			rsp_nxt.err = 1'b1;
		end else begin
			case (ofs)
				`DSGC_OFS_RUN_GATE: begin
					rsp_nxt.rdata = run_clock_gate_0_r;
				end
				`DSGC_OFS_SLP_GATE: begin
					rsp_nxt.rdata = sleep_clock_gate_0_r;
				end
				`DSGC_OFS_DEEP_GATE: begin
					rsp_nxt.rdata = deep_sleep_clock_gate_0_r & `DSGC_GATE_MASK; // see RULE8
				end
				`DSGC_OFS_RUN_CFG: begin
					rsp_nxt.rdata = run_clock_configuration_r;
				end
				`DSGC_OFS_IRQ_STAT: begin
					rsp_nxt.rdata = irq_stat_r;
				end
				`DSGC_OFS_IRQ_EN: begin
					rsp_nxt.rdata = irq_en_r;
				end
				`DSGC_OFS_IRQ_CLR: begin
					rsp_nxt.rdata = 32'h00000000;
				end
				default: begin
					rsp_nxt.err = 1'b1;
				end
			endcase
		end
	end

	// Answer captured at end of setup phase
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rsp_r <= '0;
		end else if (setup) begin
			rsp_r <= rsp_nxt;
		end
	end

	assign PREADY  = access;
	assign PRDATA  = rsp_r.rdata;
	assign PSLVERR = access & rsp_r.err;

	// Deep-sleep gate register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			deep_sleep_clock_gate_0_r <= `DSGC_GATE_RESET; // see RULE3 see RULE4
		end else if (wr_deep) begin
			deep_sleep_clock_gate_0_r <= dsgc_merge(deep_sleep_clock_gate_0_r, req.wdata,
				req.strb, `DSGC_GATE_MASK); // see RULE5 see RULE6 see RULE7 see RULE8
		end
	end

	// Run gate register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			run_clock_gate_0_r <= `DSGC_GATE_RESET;
		end else if (wr_run) begin
			run_clock_gate_0_r <= dsgc_merge(run_clock_gate_0_r, req.wdata,
				req.strb, `DSGC_GATE_MASK); // see RULE10
		end
	end

	// Sleep gate register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			sleep_clock_gate_0_r <= `DSGC_GATE_RESET;
		end else if (wr_slp) begin
			sleep_clock_gate_0_r <= dsgc_merge(sleep_clock_gate_0_r, req.wdata,
				req.strb, `DSGC_GATE_MASK); // see RULE10
		end
	end

	// Run clock configuration
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			run_clock_configuration_r <= `DSGC_CFG_RESET;
		end else if (wr_cfg) begin
			run_clock_configuration_r <= dsgc_merge(run_clock_configuration_r, req.wdata,
				req.strb, `DSGC_CFG_MASK);
		end
	end

	assign auto_gating_select = run_clock_configuration_r[`DSGC_CFG_ACG_BIT];

	// Power mode tracking
	always_comb begin
		if (DEEP_SLEEP_REQ) begin
			mode_nxt = DSGC_MODE_DEEP;
		end else if (SLEEP_REQ) begin
			mode_nxt = DSGC_MODE_SLEEP;
		end else begin
			mode_nxt = DSGC_MODE_RUN;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			mode_r <= DSGC_MODE_RUN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Gate register selection by mode
	always_comb begin
		case (mode_r)
			DSGC_MODE_RUN: begin
				gate_sel = run_clock_gate_0_r;
			end
			DSGC_MODE_SLEEP: begin
				gate_sel = auto_gating_select ? sleep_clock_gate_0_r
					: run_clock_gate_0_r; // see RULE11
			end
			DSGC_MODE_DEEP: begin
				gate_sel = auto_gating_select ? deep_sleep_clock_gate_0_r
					: run_clock_gate_0_r; // see RULE10 see RULE11 see RULE14
			end
			default: begin
				gate_sel = run_clock_gate_0_r; // see RULE14
			end
		endcase
	end

	// Gate bits per unit
	assign unit_on[`DSGC_UNIT_WDT] = gate_sel[`DSGC_BIT_WDT];
	assign unit_on[`DSGC_UNIT_HIB] = gate_sel[`DSGC_BIT_HIB];
	assign unit_on[`DSGC_UNIT_ADC] = gate_sel[`DSGC_BIT_ADC];
	assign unit_on[`DSGC_UNIT_PWM] = gate_sel[`DSGC_BIT_PWM];

	// One gate and guard per unit
	genvar gi;
	generate
		for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
			dsgc_unit_gate u_gate (
				.clk    (MCLK),
				.srst   (SRST),
				.clk_on (unit_on[gi]),           // see RULE1
				.acc    (UNIT_ACC[gi]),
				.fault  (UNIT_FAULT[gi]),        // see RULE2
				.en     (UNIT_CLK_EN[gi]),
				.gclk   (UNIT_CLK[gi])
			);
		end
	endgenerate

	assign fault_evt = UNIT_FAULT;

	// Interrupt enable
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			irq_en_r <= `DSGC_IRQ_RESET;
		end else if (wr_ien) begin
			irq_en_r <= dsgc_merge(irq_en_r, req.wdata, req.strb, `DSGC_IRQ_MASK);
		end
	end

	// Clear bits from a write to the clear register
	always_comb begin
		clr_val = 32'h00000000;
		if (wr_clr) begin
			clr_val = dsgc_merge(32'h00000000, req.wdata, req.strb, `DSGC_IRQ_MASK);
		end
	end

	// Sticky fault status, a new fault wins over a clear
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			irq_stat_r <= `DSGC_IRQ_RESET;
		end else begin
			irq_stat_r <= ((irq_stat_r & ~clr_val)
				| {{(32 - NUM_UNITS){1'b0}}, fault_evt}) & `DSGC_IRQ_MASK; // see RULE2
		end
	end

	assign IRQ = |(irq_stat_r & irq_en_r);

endmodule // dsgc_gate_ctrl

`default_nettype wire

// ===== dsgc_consts.svh
// Purpose: Constants of the deep-sleep clock gating block
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef DSGC_CONSTS_SVH
`define DSGC_CONSTS_SVH

// System control base and register offsets
`define DSGC_SYSCTL_BASE   32'h400fe000
`define DSGC_OFS_RUN_GATE  12'h100
`define DSGC_OFS_SLP_GATE  12'h110
`define DSGC_OFS_DEEP_GATE 12'h120
`define DSGC_OFS_RUN_CFG   12'h060
`define DSGC_OFS_IRQ_STAT  12'h130
`define DSGC_OFS_IRQ_EN    12'h134
`define DSGC_OFS_IRQ_CLR   12'h138

// Gating register layout and reset value
`define DSGC_GATE_RESET    32'h00000040
`define DSGC_GATE_MASK     32'h00110048
`define DSGC_BIT_WDT       3
`define DSGC_BIT_HIB       6
`define DSGC_BIT_ADC       16
`define DSGC_BIT_PWM       20

// Run clock configuration layout
`define DSGC_CFG_RESET     32'h00000000
`define DSGC_CFG_MASK      32'h00000800
`define DSGC_CFG_ACG_BIT   11

// Interrupt registers
`define DSGC_IRQ_RESET     32'h00000000
`define DSGC_IRQ_MASK      32'h0000000f

// Unit indices inside the unit vectors
`define DSGC_UNIT_WDT      0
`define DSGC_UNIT_HIB      1
`define DSGC_UNIT_ADC      2
`define DSGC_UNIT_PWM      3
`define DSGC_NUM_UNITS     4

`endif

// ===== dsgc_pkg.sv
// Purpose: Types of the deep-sleep clock gating block
// Assumes: Constants come from dsgc_consts.svh
// Notes:   Types only
`default_nettype none
package dsgc_pkg;

	// Power mode, one-hot
	typedef enum logic [2:0] {
		DSGC_MODE_RUN   = 3'b001,
		DSGC_MODE_SLEEP = 3'b010,
		DSGC_MODE_DEEP  = 3'b100
	} dsgc_mode_type;

	// APB request driven straight from the bus inputs, not registered
	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic [31:0] wdata;
		logic [3:0]  strb;
	} dsgc_apb_req_type;

	// APB answer prepared in the setup phase
	typedef struct packed {
		logic [31:0] rdata;
		logic        err;
	} dsgc_apb_rsp_type;

endpackage

`default_nettype wire

// ===== dsgc_unit_gate.sv
// Purpose: Clock gate and access guard for one peripheral unit
// Assumes: clk_on is synchronous to clk
// Notes:   Enable is held through the high clock phase for a clean gate
`timescale 1ns/10ps
`default_nettype none

module dsgc_unit_gate (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Gate control
	input  wire logic clk_on,
	// Unit access
	input  wire logic acc,
	output logic      fault,
	// Unit clock
	output logic      en,
	output logic      gclk
);

	logic en_r;
	logic en_low_r;

	// Unit enable follows the selected gate bit
	always_ff @(posedge clk) begin
		if (srst) begin
			en_r <= 1'b0;
		end else begin
			en_r <= clk_on;
		end
	end

	// Enable held stable while clock is high
	always_ff @(negedge clk) begin
		if (srst) begin
			en_low_r <= 1'b0;
		end else begin
			en_low_r <= en_r;
		end
	end

	assign gclk  = clk & en_low_r;
	assign en    = en_r;
	assign fault = acc & ~en_r;

endmodule // dsgc_unit_gate

`default_nettype wire

// ===== dsgc_gate_ctrl_asserts.sv
// Purpose: Port checks of the gate control block
// Assumes: Bound to every dsgc_gate_ctrl
// Notes:   One clock domain
`timescale 1ns/10ps
`default_nettype none
module dsgc_gate_ctrl_asserts #(
	parameter int NUM_UNITS = 4
) (
	// Clock and reset
	input wire logic                 MCLK,
	input wire logic                 SRST,
	// APB
	input wire logic                 PSEL,
	input wire logic                 PENABLE,
	input wire logic                 PWRITE,
	input wire logic [31:0]          PADDR,
	input wire logic                 PREADY,
	input wire logic [31:0]          PRDATA,
	input wire logic                 PSLVERR,
	// Modes and units
	input wire logic                 SLEEP_REQ,
	input wire logic                 DEEP_SLEEP_REQ,
	input wire logic [NUM_UNITS-1:0] UNIT_ACC,
	input wire logic [NUM_UNITS-1:0] UNIT_FAULT,
	input wire logic [NUM_UNITS-1:0] UNIT_CLK_EN,
	input wire logic                 IRQ
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);
	wire logic acc = PSEL && PENABLE;
	wire logic wr  = acc && PWRITE;
	property p_ready; PREADY == acc; endproperty
	a_ready: assert property (p_ready) else $error("ready off");
	property p_idle; !PSEL |-> !PREADY && !PSLVERR; endproperty
	a_idle: assert property (p_idle) else $error("idle answer");
	property p_fault; UNIT_FAULT == (UNIT_ACC & ~UNIT_CLK_EN); endproperty
	a_fault: assert property (p_fault) else $error("fault wrong");
	property p_base; acc && PADDR[31:12] != 20'h400fe |-> PSLVERR && PRDATA == 32'h0; endproperty
	a_base: assert property (p_base) else $error("base not refused");
	property p_deep; acc && PADDR == 32'h400fe120 |-> !PSLVERR; endproperty
	a_deep: assert property (p_deep) else $error("gate refused");
	property p_rsvd; acc && !PWRITE && PADDR == 32'h400fe120 |-> !(PRDATA & ~32'h00110048); endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
	property p_irq; $rose(IRQ) |-> |$past(UNIT_FAULT) || $past(wr); endproperty
	a_irq: assert property (p_irq) else $error("irq no cause");
	property p_en;
		$changed(UNIT_CLK_EN) |-> $past(wr) || $past(wr, 2) || $past(SRST, 2)
			|| $past(DEEP_SLEEP_REQ, 2) != $past(DEEP_SLEEP_REQ, 3)
			|| $past(SLEEP_REQ, 2) != $past(SLEEP_REQ, 3);
	endproperty
	a_en: assert property (p_en) else $error("enable no cause");
endmodule // dsgc_gate_ctrl_asserts
bind dsgc_gate_ctrl dsgc_gate_ctrl_asserts #(.NUM_UNITS(NUM_UNITS)) i_chk (
	.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
	.SLEEP_REQ(SLEEP_REQ), .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .UNIT_ACC(UNIT_ACC),
	.UNIT_FAULT(UNIT_FAULT), .UNIT_CLK_EN(UNIT_CLK_EN), .IRQ(IRQ)
);
`default_nettype wire

// ===== tb.sv
// Purpose: Register and gating tests
// Assumes: Zero wait APB slave
// Notes:   Deep gate acts only with auto gating
`timescale 1ns/10ps
`default_nettype none
`include "dsgc_consts.svh"
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sel = 1'b0;
	logic        en  = 1'b0;
	logic        we  = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wd  = 32'h0;
	logic        slp = 1'b0;
	logic        dsl = 1'b0;
	logic [3:0]  uac = 4'h0;
	wire logic   rdy, err, irq;
	wire logic [31:0] rdt;
	wire logic [3:0]  flt, uen, ucl;
	logic [31:0] rv;
	logic        re;
	int          failures = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          bits [4] = '{3, 6, 16, 20};
	always #5 clk = ~clk;
	dsgc_gate_ctrl i_dsgc_gate_ctrl (
		.MCLK(clk), .SRST(rst), .PSEL(sel), .PENABLE(en), .PWRITE(we),
		.PADDR(adr), .PWDATA(wd), .PSTRB(4'hf), .PREADY(rdy), .PRDATA(rdt),
		.PSLVERR(err), .SLEEP_REQ(slp), .DEEP_SLEEP_REQ(dsl), .UNIT_ACC(uac),
		.UNIT_FAULT(flt), .UNIT_CLK_EN(uen), .UNIT_CLK(ucl), .IRQ(irq)
	);
	function automatic logic [31:0] ad(input logic [11:0] o);
		return `DSGC_SYSCTL_BASE + {20'h0, o};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, x);
		n_tests++;
		if (s !== x) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		sel <= 1'b1;
		we  <= w;
		adr <= a;
		wd  <= d;
		@(posedge clk);
		en <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rv = rdt;
		re = err;
		sel <= 1'b0;
		en  <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [31:0] a, x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk(nm, rv, x);
		chk(nm, {31'h0, re}, {31'h0, xe});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		chk("en", {28'h0, uen}, 32'h2);
		rd("deep", ad(`DSGC_OFS_DEEP_GATE), 32'h40, 1'b0);
		rd("cfg", ad(`DSGC_OFS_RUN_CFG), 32'h0, 1'b0);
		$display("test reset done");
		apb(1'b1, ad(`DSGC_OFS_DEEP_GATE), 32'hffffffff);
		rd("deep", ad(`DSGC_OFS_DEEP_GATE), 32'h00110048, 1'b0);
		dsl <= 1'b1;
		tick(3);
		chk("en", {28'h0, uen}, 32'h2);
		apb(1'b1, ad(`DSGC_OFS_RUN_CFG), 32'h00000800);
		tick(3);
		chk("en", {28'h0, uen}, 32'hf);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ad(`DSGC_OFS_DEEP_GATE), 32'h1 << bits[i]);
			tick(3);
			chk("en", {28'h0, uen}, 32'h1 << i);
			chk("clk", {28'h0, ucl}, 32'h1 << i);
			@(posedge clk);
			uac <= 4'hf;
			#1;
			chk("fault", {28'h0, flt}, 32'hf & ~(32'h1 << i));
			@(posedge clk);
			uac <= 4'h0;
		end
		rd("stat", ad(`DSGC_OFS_IRQ_STAT), 32'hf, 1'b0);
		$display("test gates done");
		apb(1'b1, ad(`DSGC_OFS_IRQ_CLR), 32'hf);
		apb(1'b1, ad(`DSGC_OFS_DEEP_GATE), 32'h0);
		apb(1'b1, ad(`DSGC_OFS_IRQ_EN), 32'hf);
		tick(1);
		chk("irq", {31'h0, irq}, 32'h0);
		@(posedge clk);
		uac <= 4'h4;
		@(posedge clk);
		uac <= 4'h0;
		#1;
		chk("irq", {31'h0, irq}, 32'h1);
		rd("stat", ad(`DSGC_OFS_IRQ_STAT), 32'h4, 1'b0);
		apb(1'b1, ad(`DSGC_OFS_IRQ_CLR), 32'h4);
		tick(1);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test fault done");
		@(posedge clk);
		dsl <= 1'b0;
		slp <= 1'b1;
		tick(3);
		chk("en", {28'h0, uen}, 32'h2);
		rd("base", 32'h40000120, 32'h0, 1'b1);
		rd("align", ad(12'h122), 32'h0, 1'b1);
		rd("hole", ad(12'h124), 32'h0, 1'b1);
		$display("test decode done");
		apb(1'b1, ad(`DSGC_OFS_SLP_GATE), 32'h00010000);
		tick(3);
		chk("en", {28'h0, uen}, 32'h4);
		rd("run", ad(`DSGC_OFS_RUN_GATE), 32'h40, 1'b0);
		apb(1'b0, ad(`DSGC_OFS_DEEP_GATE), 32'h0);
		apb(1'b1, ad(`DSGC_OFS_DEEP_GATE), rv | 32'h00100000);
		rd("deep", ad(`DSGC_OFS_DEEP_GATE), 32'h00100000, 1'b0);
		@(posedge clk);
		slp <= 1'b0;
		tick(3);
		chk("en", {28'h0, uen}, 32'h2);
		$display("test modes done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		chk("en", {28'h0, uen}, 32'h2);
		rd("deep", ad(`DSGC_OFS_DEEP_GATE), 32'h40, 1'b0);
		rd("cfg", ad(`DSGC_OFS_RUN_CFG), 32'h0, 1'b0);
		$display("test mid reset done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
